// File: logic/mcc_pkg.sv
// constants and types shared by the modem command control block
package mcc_pkg;

  localparam logic [15:0] CMD_ADDR = 16'h2200;
  localparam logic [7:0] CMD_RESET = 8'hFC;
  localparam logic [7:0] CMD_RSVD_MASK = 8'h30;
  localparam logic [7:0] CMD_RSVD_VALUE = 8'h30;

  localparam int BIT_MODEM_OFF = 7;
  localparam int BIT_MODEM_ON = 6;
  localparam int BIT_TX_ABORT = 3;
  localparam int BIT_SEND_REQ = 2;
  localparam int BIT_TX_FORCE_ON = 1;
  localparam int BIT_RX_FORCE_ON = 0;

  localparam int CLK_PERIOD_NS = 25;
  localparam int STOP_DELAY_NS = 1000;
  // least time, so round up
  localparam int STOP_DELAY_CYC = (STOP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_CNT_W = 8;

  typedef enum logic [1:0] {
    MCC_OFF,
    MCC_RX_READY,
    MCC_TX_BUSY,
    MCC_TX_STOP
  } mcc_state_t;

endpackage

// File: logic/mcc_path_sel.sv
// force-on / force-off / automatic selection for one modem circuit
module mcc_path_sel (
  input wire logic force_on, // software forces the circuit on
  input wire logic force_off, // software forces it off when force_on is low
  input wire logic auto_en, // hardware request while in automatic mode
  output logic path_en // resulting enable
);
  import mcc_pkg::*;

  wire auto_mode = !force_on && !force_off;

  // force_on wins over force_off; off only bites when on is low
  assign path_en = force_on || (auto_mode && auto_en);

endmodule

// File: logic/mcc_stop_timer.sv
// countdown for the settle time after an aborted transmission
module mcc_stop_timer (
  input wire logic sys_clk, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic load, // restart the countdown
  output logic expired // countdown has reached zero
);
  import mcc_pkg::*;

  logic [STOP_CNT_W-1:0] cnt;
  wire [STOP_CNT_W-1:0] next_cnt = load ? STOP_CNT_W'(STOP_DELAY_CYC) :
                                   (cnt != '0) ? cnt - STOP_CNT_W'(1) : cnt;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign expired = (cnt == '0);

endmodule

// File: logic/mcc_modem_ctrl.sv
// modem command register and modem on/off, abort and path enable control

module mcc_modem_ctrl
  import mcc_pkg::*;
(
  input wire logic sys_clk, // system clock, 40 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic reg_wr, // data-memory write strobe
  input wire logic reg_rd, // data-memory read strobe
  input wire logic [15:0] reg_addr, // data-memory address
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, valid the cycle after reg_rd
  input wire logic tx_path_force_off, // modulation force-off from second command register
  input wire logic rx_path_force_off, // demodulation force-off from second command register
  input wire logic tx_frame_start, // datapath began sending a packet
  input wire logic tx_frame_done, // datapath finished sending a packet
  input wire logic rx_frame_active, // datapath is receiving a packet
  output logic modem_on, // modem is in its on state
  output logic tx_pwr_en, // transmitter powered
  output logic rx_pwr_en, // receiver powered
  output logic mod_en, // modulation circuit enable
  output logic demod_en, // demodulation circuit enable
  output logic tx_abort, // one-cycle stop pulse to the transmitter
  output logic tx_launch // one-cycle send pulse to the transmitter
);
  import mcc_pkg::*;

  logic [7:0] modem_command_reg;
  mcc_state_t state;
  mcc_state_t next_state;

  // register decode
  wire wr_hit = reg_wr && (reg_addr == CMD_ADDR);
  wire rd_hit = reg_rd && (reg_addr == CMD_ADDR);
  wire modem_on_cmd = modem_command_reg[BIT_MODEM_ON];
  wire modem_off_cmd = modem_command_reg[BIT_MODEM_OFF];
  wire tx_abort_req = modem_command_reg[BIT_TX_ABORT];
  wire packet_send_req = modem_command_reg[BIT_SEND_REQ];
  wire tx_path_force_on = modem_command_reg[BIT_TX_FORCE_ON];
  wire rx_path_force_on = modem_command_reg[BIT_RX_FORCE_ON];

  // commands act on the written value itself, in the cycle of the write
  wire on_go = wr_hit && !reg_wdata[BIT_MODEM_ON];
  wire off_go = wr_hit && reg_wdata[BIT_MODEM_OFF] && reg_wdata[BIT_MODEM_ON];
  wire abort_go = wr_hit && !reg_wdata[BIT_TX_ABORT] && (state == MCC_TX_BUSY);
  wire send_go = wr_hit && !reg_wdata[BIT_SEND_REQ] && (state == MCC_RX_READY);
  wire stop_expired;
  wire stop_load = abort_go && !off_go;

  always_comb begin
    next_state = state;
    unique case (state)
      MCC_OFF: begin
        if (on_go) begin
          next_state = MCC_RX_READY;
        end
      end
      MCC_RX_READY: begin
        if (off_go) begin
          next_state = MCC_OFF;
        end else if (tx_frame_start) begin
          next_state = MCC_TX_BUSY;
        end
      end
      MCC_TX_BUSY: begin
        if (off_go) begin
          next_state = MCC_OFF;
        end else if (abort_go) begin
          next_state = MCC_TX_STOP;
        end else if (tx_frame_done) begin
          next_state = MCC_RX_READY;
        end
      end
      MCC_TX_STOP: begin
        if (off_go) begin
          next_state = MCC_OFF;
        end else if (stop_expired) begin
          next_state = MCC_RX_READY;
        end
      end
    endcase
  end

  mcc_stop_timer u_stop_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .load(stop_load),
    .expired(stop_expired)
  );

  // command register: reserved bits forced, hardware restores strobe bits
  wire [7:0] wr_value = (reg_wdata & ~CMD_RSVD_MASK) | CMD_RSVD_VALUE;
  wire [7:0] base_value = wr_hit ? wr_value : modem_command_reg;
  // restoring sets follow the stored bits, so they win over a written clear only when the stored bit is already clear
  wire on_restore = (state != MCC_OFF) && !modem_on_cmd;
  wire abort_restore = !tx_abort_req;
  wire send_restore = !packet_send_req && (state != MCC_RX_READY || tx_frame_start);
  logic [7:0] next_cmd;
  always_comb begin
    next_cmd = base_value;
    if (on_restore) begin
      next_cmd[BIT_MODEM_ON] = 1'b1;
    end
    if (abort_restore) begin
      next_cmd[BIT_TX_ABORT] = 1'b1;
    end
    if (send_restore) begin
      next_cmd[BIT_SEND_REQ] = 1'b1;
    end
  end

  // path enables from force bits and automatic requests
  wire mod_auto = (next_state == MCC_TX_BUSY);
  wire demod_auto = rx_frame_active && (next_state == MCC_RX_READY);
  // one selector per circuit: bit 0 modulation, bit 1 demodulation
  wire [1:0] path_force_on = {rx_path_force_on, tx_path_force_on};
  wire [1:0] path_force_off = {rx_path_force_off, tx_path_force_off};
  wire [1:0] path_auto = {demod_auto, mod_auto};
  wire [1:0] next_path_en;

  for (genvar p = 0; p < 2; p++) begin : g_path
    mcc_path_sel u_sel (
      .force_on(path_force_on[p]),
      .force_off(path_force_off[p]),
      .auto_en(path_auto[p]),
      .path_en(next_path_en[p])
    );
  end

  wire next_mod_en = next_path_en[0];
  wire next_demod_en = next_path_en[1];

  wire [7:0] next_rdata = rd_hit ? modem_command_reg : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= MCC_OFF;
      modem_command_reg <= CMD_RESET;
    end else begin
      state <= next_state;
      modem_command_reg <= next_cmd;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      modem_on <= 1'b0;
      tx_pwr_en <= 1'b0;
      rx_pwr_en <= 1'b0;
    end else begin
      modem_on <= (next_state != MCC_OFF);
      tx_pwr_en <= (next_state == MCC_TX_BUSY);
      rx_pwr_en <= (next_state == MCC_RX_READY);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mod_en <= 1'b0;
      demod_en <= 1'b0;
      tx_abort <= 1'b0;
      tx_launch <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      mod_en <= next_mod_en;
      demod_en <= next_demod_en;
      tx_abort <= stop_load;
      tx_launch <= send_go && !off_go;
      reg_rdata <= next_rdata;
    end
  end

  // cycles spent settling after an abort; only the checks read it
  // never wraps: the settle state lasts well under the counter range
  logic [STOP_CNT_W-1:0] stop_cycles;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || (state != MCC_TX_STOP)) begin
      stop_cycles <= '0;
    end else begin
      stop_cycles <= stop_cycles + STOP_CNT_W'(1);
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_on_entry: assert property (
    (state == MCC_OFF) && on_go |=> modem_on && rx_pwr_en)
    else $error("modem did not turn on after modem-on write");
  a_ready_state: assert property (
    modem_on && (state != MCC_TX_STOP) |-> (rx_pwr_en ^ tx_pwr_en))
    else $error("modem on but neither tx nor rx ready");
  a_auto_power: assert property (
    (state == MCC_RX_READY) && tx_frame_start && !off_go |=> tx_pwr_en && !rx_pwr_en)
    else $error("transmitter not powered at frame start");
  a_on_restore: assert property (
    modem_on && !modem_on_cmd |=> modem_on_cmd)
    else $error("modem-on bit not restored");
  a_abort_stop: assert property (
    stop_load |=> tx_abort && !tx_pwr_en ##1 !tx_abort)
    else $error("abort did not stop transmission");
  a_stop_delay: assert property (
    stop_load |=> !rx_pwr_en [*8] ##[32:36] (rx_pwr_en || !modem_on))
    else $error("receive-ready not reached after stop delay");
  a_tx_force: assert property (
    tx_path_force_on |=> mod_en)
    else $error("modulation not forced on");
  a_tx_force_off: assert property (
    !tx_path_force_on && tx_path_force_off |=> !mod_en)
    else $error("modulation not forced off");
  a_rx_force: assert property (
    rx_path_force_on |=> demod_en)
    else $error("demodulation not forced on");
  a_rx_auto: assert property (
    !rx_path_force_on && !rx_path_force_off && demod_auto |=> demod_en)
    else $error("demodulation not enabled during reception");
  a_rx_tx_off: assert property (
    tx_pwr_en && !$past(rx_path_force_on) && !$past(rx_path_force_off) |-> !demod_en)
    else $error("demodulation enabled during transmission");
  a_rx_force_off: assert property (
    !rx_path_force_on && rx_path_force_off |=> !demod_en)
    else $error("demodulation not forced off");
  a_rsvd_read: assert property (
    rd_hit |=> (reg_rdata & CMD_RSVD_MASK) == CMD_RSVD_VALUE)
    else $error("reserved bits read wrong");
  a_off_cmd: assert property (
    off_go |=> !modem_on && !tx_pwr_en && !rx_pwr_en)
    else $error("modem not powered down by modem-off write");

  a_stay_off: assert property (
    !modem_on && !on_go |=> !modem_on)
    else $error("modem turned on without a modem-on write");
  a_on_kept: assert property (
    modem_on && !off_go |=> modem_on)
    else $error("modem left the on state without a modem-off write");
  a_power_excl: assert property (
    !(tx_pwr_en && rx_pwr_en))
    else $error("transmitter and receiver powered together");
  a_power_needs_on: assert property (
    tx_pwr_en || rx_pwr_en |-> modem_on)
    else $error("radio powered while modem is off");
  a_frame_done: assert property (
    (state == MCC_TX_BUSY) && tx_frame_done && !off_go && !abort_go |=> rx_pwr_en && !tx_pwr_en)
    else $error("receiver not powered after frame end");
  a_abort_idle: assert property (
    (state == MCC_RX_READY) && wr_hit && !reg_wdata[BIT_TX_ABORT] |=> !tx_abort)
    else $error("abort pulse without a transmission");
  a_abort_pulse: assert property (
    tx_abort |=> !tx_abort)
    else $error("abort pulse longer than one cycle");
  a_stop_hold: assert property (
    (state == MCC_TX_STOP) && !off_go && !stop_expired |=> !rx_pwr_en && !tx_pwr_en)
    else $error("settle wait left early");
  a_stop_exact: assert property (
    (state == MCC_TX_STOP) && (next_state == MCC_RX_READY) |-> stop_cycles == STOP_DELAY_CYC)
    else $error("settle wait has the wrong length");
  a_stop_bound: assert property (
    (state == MCC_TX_STOP) |-> stop_cycles <= STOP_DELAY_CYC)
    else $error("settle wait overran");
  a_mod_auto: assert property (
    !tx_path_force_on && !tx_path_force_off |=> mod_en == tx_pwr_en)
    else $error("automatic modulation does not follow transmission");
  a_tx_on_wins: assert property (
    tx_path_force_on && tx_path_force_off |=> mod_en)
    else $error("modulation force-off overrode force-on");
  a_rx_on_wins: assert property (
    rx_path_force_on && rx_path_force_off |=> demod_en)
    else $error("demodulation force-off overrode force-on");
  a_rx_idle_off: assert property (
    !rx_path_force_on && !rx_path_force_off && !rx_frame_active |=> !demod_en)
    else $error("demodulation enabled with no reception");
  a_rdata_value: assert property (
    rd_hit |=> reg_rdata == $past(modem_command_reg))
    else $error("read data differs from register");
  a_rdata_idle: assert property (
    !rd_hit |=> reg_rdata == 8'h00)
    else $error("read data without a read");
  a_off_bit: assert property (
    off_go |=> modem_off_cmd)
    else $error("modem-off bit not stored");
  a_off_quiet: assert property (
    !modem_on |-> !tx_pwr_en && !rx_pwr_en && !tx_abort && !tx_launch)
    else $error("activity while modem is off");

  c_turn_on: cover property ((state == MCC_OFF) ##1 modem_on);
  c_abort_path: cover property (stop_load ##[30:50] rx_pwr_en);
  c_rx_auto: cover property (demod_auto ##1 demod_en);
  c_off_cmd: cover property (modem_on ##1 off_go ##1 !modem_on);
  c_stop_expire: cover property ((state == MCC_TX_STOP) && stop_expired);

endmodule

// File: verif/tb.sv
// self-checking bench for the modem command control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mcc_pkg::*;

  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic tx_force_off = 1'b0;
  logic rx_force_off = 1'b0;
  logic tx_frame_start = 1'b0;
  logic tx_frame_done = 1'b0;
  logic rx_frame_active = 1'b0;
  logic modem_on, tx_pwr_en, rx_pwr_en, mod_en, demod_en, tx_abort, tx_launch;
  logic rd_taken = 1'b0;
  logic [7:0] rd_q[$];
  int mismatches = 0;
  int tests_run = 0;
  int n;

  always #12.5 sys_clk = ~sys_clk;

  mcc_modem_ctrl u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tx_path_force_off(tx_force_off), .rx_path_force_off(rx_force_off),
    .tx_frame_start(tx_frame_start), .tx_frame_done(tx_frame_done),
    .rx_frame_active(rx_frame_active), .modem_on(modem_on), .tx_pwr_en(tx_pwr_en),
    .rx_pwr_en(rx_pwr_en), .mod_en(mod_en), .demod_en(demod_en), .tx_abort(tx_abort),
    .tx_launch(tx_launch));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // read data is registered, so it is judged one cycle after the strobe
  always @(posedge sys_clk) rd_taken <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_taken) begin
      if (rd_q.size() == 0) chk("unexpected read", 8'h00, 8'hFF);
      else chk("read data", rd_q.pop_front(), reg_rdata);
    end
  end

  task automatic idle(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    rd_q.push_back(exp);
    @(negedge sys_clk);
    reg_rd = 1'b0;
  endtask

  task automatic pulse(input bit done);
    @(negedge sys_clk);
    if (done) tx_frame_done = 1'b1;
    else tx_frame_start = 1'b1;
    @(negedge sys_clk);
    tx_frame_done = 1'b0;
    tx_frame_start = 1'b0;
  endtask

  // send request accepted, then the datapath starts the frame
  task automatic launch;
    wr(CMD_ADDR, 8'h78);
    chk("tx_launch", 8'h01, {7'h00, tx_launch});
    idle(1);
    chk("tx_launch end", 8'h00, {7'h00, tx_launch});
    pulse(1'b0);
    idle(1);
    chk("tx_pwr_en", 8'h01, {7'h00, tx_pwr_en});
    chk("rx_pwr_en", 8'h00, {7'h00, rx_pwr_en});
    chk("mod_en auto", 8'h01, {7'h00, mod_en});
    chk("demod_en auto", 8'h00, {7'h00, demod_en});
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(15));
    idle(4);
    sys_rst = 1'b0;
    chk("modem_on reset", 8'h00, {7'h00, modem_on});
    rd(CMD_ADDR, CMD_RESET);
    rd(CMD_ADDR + 16'h0001, 8'h00);
    wr(CMD_ADDR, 8'hCF);
    rd(CMD_ADDR, 8'hFF);
    wr(CMD_ADDR, 8'h3F);
    chk("modem_on", 8'h01, {7'h00, modem_on});
    chk("rx_pwr_en on", 8'h01, {7'h00, rx_pwr_en});
    idle(1);
    rd(CMD_ADDR, 8'h7F);
    // every force-on / force-off pairing, random reception activity
    for (int i = 0; i < 16; i++) begin
      rx_frame_active = 1'($urandom);
      tx_force_off = i[2];
      rx_force_off = i[0];
      wr(CMD_ADDR, {6'h1F, i[3], i[1]});
      idle(2);
      chk("mod_en", {7'h00, i[3]}, {7'h00, mod_en});
      chk("demod_en", {7'h00, i[1] | (!i[1] & !i[0] & rx_frame_active)},
          {7'h00, demod_en});
    end
    tx_force_off = 1'b0;
    rx_force_off = 1'b0;
    rx_frame_active = 1'b1;
    launch();
    pulse(1'b1);
    idle(1);
    chk("rx_pwr_en after done", 8'h01, {7'h00, rx_pwr_en});
    launch();
    wr(CMD_ADDR, 8'h74);
    chk("tx_abort", 8'h01, {7'h00, tx_abort});
    chk("tx_pwr_en abort", 8'h00, {7'h00, tx_pwr_en});
    n = 0;
    while (rx_pwr_en !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    chk("stop delay", 8'h01,
        {7'h00, n >= STOP_DELAY_CYC - 1 && n <= STOP_DELAY_CYC + 2});
    if (n >= 100) print_verdict();
    rd(CMD_ADDR, 8'h7C);
    wr(CMD_ADDR, 8'hFC);
    idle(2);
    chk("modem_on off", 8'h00, {7'h00, modem_on});
    chk("demod_en off", 8'h00, {7'h00, demod_en});
    pulse(1'b0);
    idle(1);
    chk("tx_pwr_en off", 8'h00, {7'h00, tx_pwr_en});
    rd(CMD_ADDR, CMD_RESET);
    idle(2);
    if (rd_q.size() != 0) chk("reads left", 8'h00, 8'(rd_q.size()));
    print_verdict();
  end
endmodule
